// ==== pcrb_register_bank.sv ====
// Operation
// R1: Protection configs 00h-02h, ramp tracking 03h, interleave/frequency 04h.
// R2: On delay 05h, off delay 06h, setpoint 07h, current limit 08h, duty 09h.
// R3: Denominators at 0Ah-0Ch, numerator byte pairs at 0Dh-14h.
// R4: Run control 15h, status 16h, voltage/current/temperature 17h-19h.
// R5: All may change while running except coefficients, frequency, duty cap.
// R6: Setpoint is full 8-bit read/write, resets to zero; 00h is 0.5V.
// R7: Setpoint code picks one of 256 levels from 0.5 V to 5.5 V.
// R8: Three bands: 12.5 mV, 25 mV and 50 mV steps.
// R9: Unimplemented bits read zero whatever was written.
// R10: Host programs delays and slew rates through on, off and ramp registers.
// R11: Nonzero load regulation lowers the output as current rises.
// R12: Host groups parallel converters on one bus before margining them.
// R13: Setup registers load defaults at power-up; writes overwrite them.
// R14: Codes 0-120 fine, 121-250 medium from 2.025V, 251-255 coarse from 5.3V.
// R15: Locked-register writes while output is on leave values unchanged.
module pcrb_register_bank
    import pcrb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input pcrb_req_t req,
    output pcrb_rsp_t rsp,
    input wire logic output_on,
    input pcrb_telemetry_t telemetry,
    output pcrb_config_t config_out,
    output logic [15:0] target_tenth_mv
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [SETUP_COUNT-1:0][7:0] setup;
        logic [7:0] run_ctrl;
        logic [1:0] on_sync;
        logic [1:0][$bits(pcrb_telemetry_t)-1:0] tel_sync;
        logic ack;
        logic [7:0] rdata;
    } pcrb_state_t;

    pcrb_state_t state_reg;
    pcrb_state_t state_next;
    pcrb_telemetry_t tel_now;
    logic running;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // True for registers that may change only while the output is off.
    function automatic logic pcrb_locked(input logic [7:0] a);
        pcrb_locked = (a == ADDR_PHASE_AND_SWITCH_FREQ_CONFIG) ||
                      (a == ADDR_DUTY_CAP) ||
                      ((a >= ADDR_FILTER_DENOMINATOR_1) &&
                       (a <= ADDR_FILTER_NUMERATOR_3_BYTE_B)); // see R5
    endfunction : pcrb_locked

    // Implemented bits of each setup register.
    function automatic logic [7:0] pcrb_mask(input logic [7:0] a);
        unique case (a)
            ADDR_RAMP_RATE_CONFIG: pcrb_mask = MASK_RAMP_RATE_CONFIG;
            ADDR_OFF_DELAY: pcrb_mask = MASK_OFF_DELAY;
            default: pcrb_mask = MASK_FULL;
        endcase
    endfunction : pcrb_mask

    // Power-up default of each setup register.
    function automatic logic [7:0] pcrb_default(input logic [7:0] a);
        unique case (a)
            ADDR_PROTECTION_CONFIG_1,
            ADDR_PROTECTION_CONFIG_2,
            ADDR_PROTECTION_CONFIG_3: pcrb_default = RST_PROTECTION_CONFIG;
            ADDR_RAMP_RATE_CONFIG: pcrb_default = RST_RAMP_RATE_CONFIG;
            ADDR_PHASE_AND_SWITCH_FREQ_CONFIG:
                pcrb_default = RST_PHASE_AND_SWITCH_FREQ;
            ADDR_ON_DELAY: pcrb_default = RST_ON_DELAY;
            ADDR_OFF_DELAY: pcrb_default = RST_OFF_DELAY;
            ADDR_OUTPUT_VOLTAGE_SETPOINT:
                pcrb_default = RST_OUTPUT_VOLTAGE_SETPOINT; // see R6
            ADDR_LOAD_LINE_CURRENT_LIMIT:
                pcrb_default = RST_LOAD_LINE_CURRENT_LIMIT;
            ADDR_DUTY_CAP: pcrb_default = RST_DUTY_CAP;
            default: pcrb_default = RST_FILTER_COEFF;
        endcase
    endfunction : pcrb_default

    // Builds the full power-up image of the setup registers.
    function automatic logic [SETUP_COUNT-1:0][7:0] pcrb_defaults();
        logic [SETUP_COUNT-1:0][7:0] img;
        img = '0;
        for (int i = 0; i < SETUP_COUNT; i++)
        begin
            img[i] = pcrb_default(8'(i)) & pcrb_mask(8'(i)); // see R13
        end
        pcrb_defaults = img;
    endfunction : pcrb_defaults

    // Constant power-up image, so the reset branch loads only a constant.
    localparam logic [SETUP_COUNT-1:0][7:0] SETUP_DEFAULTS = pcrb_defaults();

    // ------------------------------------------------------------------
    // Synchronised inputs
    // ------------------------------------------------------------------
    // Only the second stage of each synchroniser is used.
    assign running = state_reg.on_sync[1];
    assign tel_now = pcrb_telemetry_t'(state_reg.tel_sync[1]);

    // ------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------
    // Writes land in the next state; reads answer one cycle later.
    always_comb
    begin
        state_next = state_reg;
        state_next.on_sync = {state_reg.on_sync[0], output_on};
        state_next.tel_sync = {state_reg.tel_sync[0], telemetry};
        state_next.ack = req.wr || req.rd;
        state_next.rdata = state_reg.rdata;

        // Setup registers 00h-14h take writes unless locked while on.
        if (req.wr)
        begin
            if (req.addr <= ADDR_FILTER_NUMERATOR_3_BYTE_B) // see R1
            begin
                if (!(pcrb_locked(req.addr) && running)) // see R15
                begin
                    state_next.setup[req.addr[4:0]] =
                        req.wdata & pcrb_mask(req.addr); // see R9
                end
            end
            else if (req.addr == ADDR_OPERATION_CONTROL) // see R4
            begin
                state_next.run_ctrl = req.wdata;
            end
        end

        // Read multiplexer; unmapped reads return 00h, write-only cycles keep rdata.
        if (req.rd)
        begin
            if (req.addr <= ADDR_FILTER_NUMERATOR_3_BYTE_B) // see R3
            begin
                state_next.rdata = state_reg.setup[req.addr[4:0]];
            end
            else
            begin
                unique case (req.addr)
                    ADDR_OPERATION_CONTROL:
                        state_next.rdata = state_reg.run_ctrl; // see R4
                    ADDR_CONDITION_FLAGS:
                        state_next.rdata = tel_now.flags; // see R4
                    ADDR_OUTPUT_VOLTAGE_READING:
                        state_next.rdata = tel_now.voltage; // see R4
                    ADDR_OUTPUT_CURRENT_READING:
                        state_next.rdata = tel_now.current; // see R4
                    ADDR_TEMPERATURE_READING:
                        state_next.rdata = tel_now.temperature; // see R4
                    default: state_next.rdata = READ_UNMAPPED;
                endcase
            end
        end
    end

    // Registers the whole state; reset loads the power-up defaults.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= '0;
            state_reg.setup <= SETUP_DEFAULTS; // see R13
            state_reg.run_ctrl <= RST_OPERATION_CONTROL;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rsp.ack = state_reg.ack;
    assign rsp.rdata = state_reg.rdata;
    assign config_out.setup = state_reg.setup; // see R2
    assign config_out.run_ctrl = state_reg.run_ctrl;

    // Setpoint decoding with droop from the synchronised current reading.
    pcrb_setpoint_decoder u_decoder (
        .clk(clk),
        .reset(reset),
        .code(state_reg.setup[ADDR_OUTPUT_VOLTAGE_SETPOINT[4:0]]),
        .slope(state_reg.setup[ADDR_LOAD_LINE_CURRENT_LIMIT[4:0]]
               [LOAD_SLOPE_LSB +: LOAD_SLOPE_WIDTH]),
        .current(tel_now.current),
        .target_tenth_mv(target_tenth_mv)
    );

endmodule : pcrb_register_bank

// ==== pcrb_pkg.sv ====
package pcrb_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_PROTECTION_CONFIG_1 = 8'h00;
    localparam logic [7:0] ADDR_PROTECTION_CONFIG_2 = 8'h01;
    localparam logic [7:0] ADDR_PROTECTION_CONFIG_3 = 8'h02;
    localparam logic [7:0] ADDR_RAMP_RATE_CONFIG = 8'h03;
    localparam logic [7:0] ADDR_PHASE_AND_SWITCH_FREQ_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_ON_DELAY = 8'h05;
    localparam logic [7:0] ADDR_OFF_DELAY = 8'h06;
    localparam logic [7:0] ADDR_OUTPUT_VOLTAGE_SETPOINT = 8'h07;
    localparam logic [7:0] ADDR_LOAD_LINE_CURRENT_LIMIT = 8'h08;
    localparam logic [7:0] ADDR_DUTY_CAP = 8'h09;
    localparam logic [7:0] ADDR_FILTER_DENOMINATOR_1 = 8'h0A;
    localparam logic [7:0] ADDR_FILTER_DENOMINATOR_2 = 8'h0B;
    localparam logic [7:0] ADDR_FILTER_DENOMINATOR_3 = 8'h0C;
    localparam logic [7:0] ADDR_FILTER_NUMERATOR_0_LOW = 8'h0D;
    localparam logic [7:0] ADDR_FILTER_NUMERATOR_0_HIGH = 8'h0E;
    localparam logic [7:0] ADDR_FILTER_NUMERATOR_1_LOW = 8'h0F;
    localparam logic [7:0] ADDR_FILTER_NUMERATOR_1_HIGH = 8'h10;
    localparam logic [7:0] ADDR_FILTER_NUMERATOR_2_LOW = 8'h11;
    localparam logic [7:0] ADDR_FILTER_NUMERATOR_2_HIGH = 8'h12;
    localparam logic [7:0] ADDR_FILTER_NUMERATOR_3_BYTE_A = 8'h13;
    localparam logic [7:0] ADDR_FILTER_NUMERATOR_3_BYTE_B = 8'h14;
    localparam logic [7:0] ADDR_OPERATION_CONTROL = 8'h15;
    localparam logic [7:0] ADDR_CONDITION_FLAGS = 8'h16;
    localparam logic [7:0] ADDR_OUTPUT_VOLTAGE_READING = 8'h17;
    localparam logic [7:0] ADDR_OUTPUT_CURRENT_READING = 8'h18;
    localparam logic [7:0] ADDR_TEMPERATURE_READING = 8'h19;

    // Number of setup registers, 00h through 14h.
    localparam int SETUP_COUNT = 21;

    // ------------------------------------------------------------------
    // Power-up defaults and implemented-bit masks
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PROTECTION_CONFIG = 8'h00;
    localparam logic [7:0] RST_RAMP_RATE_CONFIG = 8'h08;
    localparam logic [7:0] RST_PHASE_AND_SWITCH_FREQ = 8'h00;
    localparam logic [7:0] RST_ON_DELAY = 8'h00;
    localparam logic [7:0] RST_OFF_DELAY = 8'h00;
    localparam logic [7:0] RST_OUTPUT_VOLTAGE_SETPOINT = 8'h00;
    localparam logic [7:0] RST_LOAD_LINE_CURRENT_LIMIT = 8'h00;
    localparam logic [7:0] RST_DUTY_CAP = 8'h00;
    localparam logic [7:0] RST_FILTER_COEFF = 8'h00;
    localparam logic [7:0] RST_OPERATION_CONTROL = 8'h00;
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] MASK_RAMP_RATE_CONFIG = 8'h7F;
    localparam logic [7:0] MASK_OFF_DELAY = 8'h3F;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ------------------------------------------------------------------
    // Setpoint decoding, voltages in units of 0.1 mV
    // ------------------------------------------------------------------
    localparam logic [7:0] SP_FINE_LAST = 8'h78;      // Code 120.
    localparam logic [7:0] SP_MID_FIRST = 8'h79;      // Code 121.
    localparam logic [7:0] SP_MID_LAST = 8'hFA;       // Code 250.
    localparam logic [7:0] SP_COARSE_FIRST = 8'hFB;   // Code 251.
    localparam logic [15:0] SP_FINE_BASE = 16'h1388;   // 0.5000 V.
    localparam logic [15:0] SP_FINE_STEP = 16'h007D;   // 12.5 mV.
    localparam logic [15:0] SP_MID_BASE = 16'h4F1A;    // 2.025 V.
    localparam logic [15:0] SP_MID_STEP = 16'h00FA;    // 25 mV.
    localparam logic [15:0] SP_COARSE_BASE = 16'hCF08; // 5.3 V.
    localparam logic [15:0] SP_COARSE_STEP = 16'h01F4; // 50 mV.

    // Load regulation slope sits in the low nibble of the limit register.
    localparam int LOAD_SLOPE_LSB = 0;
    localparam int LOAD_SLOPE_WIDTH = 4;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcrb_req_t;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
    } pcrb_rsp_t;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] voltage;
        logic [7:0] current;
        logic [7:0] temperature;
    } pcrb_telemetry_t;

    typedef struct packed {
        logic [SETUP_COUNT-1:0][7:0] setup;
        logic [7:0] run_ctrl;
    } pcrb_config_t;

endpackage : pcrb_pkg

// ==== pcrb_setpoint_decoder.sv ====
module pcrb_setpoint_decoder
    import pcrb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] code,
    input wire logic [LOAD_SLOPE_WIDTH-1:0] slope,
    input wire logic [7:0] current,
    output logic [15:0] target_tenth_mv
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] target;
    } pcrb_dec_state_t;

    pcrb_dec_state_t state_reg;
    pcrb_dec_state_t state_next;
    logic [15:0] nominal;
    logic [15:0] droop;

    // Maps a code onto the three resolution bands.
    function automatic logic [15:0] pcrb_decode(input logic [7:0] c);
        logic [15:0] idx;
        idx = 16'h0000;
        if (c <= SP_FINE_LAST) // see R14
        begin
            idx = {8'h00, c};
            pcrb_decode = 16'(SP_FINE_BASE + idx * SP_FINE_STEP); // see R8
        end
        else if (c <= SP_MID_LAST) // see R14
        begin
            idx = {8'h00, 8'(c - SP_MID_FIRST)};
            pcrb_decode = 16'(SP_MID_BASE + idx * SP_MID_STEP); // see R8
        end
        else
        begin
            idx = {8'h00, 8'(c - SP_COARSE_FIRST)};
            pcrb_decode = 16'(SP_COARSE_BASE + idx * SP_COARSE_STEP); // see R8
        end
    endfunction : pcrb_decode

    // ------------------------------------------------------------------
    // Decode and droop
    // ------------------------------------------------------------------
    // The target falls with current when a slope is set, never below zero.
    always_comb
    begin
        state_next = state_reg;
        nominal = pcrb_decode(code); // see R7
        // Both factors are widened first so the product keeps all 12 bits.
        droop = {4'h0, 12'({8'h00, slope} * {4'h0, current})}; // see R11
        if (droop >= nominal)
        begin
            state_next.target = 16'h0000;
        end
        else
        begin
            state_next.target = 16'(nominal - droop); // see R11
        end
    end

    // Registers the target.
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign target_tenth_mv = state_reg.target;

endmodule : pcrb_setpoint_decoder

// ==== pcrb_asserts.sv ====
module pcrb_asserts
    import pcrb_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input pcrb_req_t req,
    input pcrb_rsp_t rsp,
    input wire logic output_on,
    input pcrb_telemetry_t telemetry,
    input pcrb_config_t config_out,
    input wire logic [15:0] target_tenth_mv
);
    // ------------------------------------------------------------------
    // Register port checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Flags a write aimed at a register that is locked while running.
    logic lk;
    assign lk = req.wr && (req.addr == 8'h04 || req.addr == 8'h09
        || (req.addr >= 8'h0A && req.addr <= 8'h14));

    chk_ack_follows_req: assert property
        ((req.wr || req.rd) |=> rsp.ack)
        else $error("ack missing after request");
    chk_ack_needs_req: assert property
        (rsp.ack |-> $past(req.wr || req.rd))
        else $error("ack without request");
    chk_rdata_holds: assert property
        (!rsp.ack |-> $stable(rsp.rdata))
        else $error("read data moved without read");
    chk_setpoint_write: assert property
        (req.wr && req.addr == 8'h07
        |=> config_out.setup[7] == $past(req.wdata))
        else $error("setpoint not written");
    chk_ramp_mask: assert property (config_out.setup[3][7] == 1'b0)
        else $error("ramp bit 7 set");
    chk_off_mask: assert property (config_out.setup[6][7:6] == 2'h0)
        else $error("off delay bits 7:6 set");
    chk_lock_hold: assert property
        (lk && output_on && $past(output_on)
        && $past(output_on, 2) |=> $stable(config_out.setup))
        else $error("locked register changed while on");
    chk_ro_write: assert property (req.wr && req.addr >= 8'h16
        |=> $stable(config_out))
        else $error("read-only write changed state");
    chk_decode_top: assert property
        ($past(config_out.setup[8][3:0]) == 4'h0
        && $past(config_out.setup[7]) == 8'hFB
        |-> target_tenth_mv == 16'hCF08)
        else $error("coarse band base wrong");

    cov_setpoint: cover property (req.wr && req.addr == 8'h07);
    cov_lock: cover property (lk && output_on);
    cov_read: cover property (req.rd ##1 rsp.ack);
endmodule : pcrb_asserts

// ==== pcrb_host_model.sv ====
module pcrb_host_model
    import pcrb_pkg::*;
(
    input wire logic clk,
    output pcrb_req_t req,
    input pcrb_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // One request pulse, then a bounded wait for the acknowledge.
    // ------------------------------------------------------------------
    // This host drives one converter alone, so no parallel grouping is
    // needed before any margining.
    initial req = '0;

    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q, output bit ok);
        int n;
        ok = 1'b0;
        q = 8'h00;
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        // The answer is taken at the rising edge that samples ack high.
        for (n = 0; n < 4 && !ok; n++)
        begin
            @(posedge clk);
            if (rsp.ack === 1'b1)
            begin
                ok = 1'b1;
                q = rsp.rdata;
            end
        end
    endtask : xfer
endmodule : pcrb_host_model

// ==== tb_top.sv ====
module tb_top
    import pcrb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic reset;
    logic output_on;
    pcrb_req_t req;
    pcrb_rsp_t rsp;
    pcrb_telemetry_t telemetry;
    pcrb_config_t config_out;
    logic [15:0] target_tenth_mv;
    int miscompares;
    int tests_run;

    pcrb_register_bank u_pcrb_register_bank (.clk(clk), .reset(reset),
        .req(req), .rsp(rsp), .output_on(output_on), .telemetry(telemetry),
        .config_out(config_out), .target_tenth_mv(target_tenth_mv));
    pcrb_host_model u_pcrb_host_model (.clk(clk), .req(req), .rsp(rsp));

    // ------------------------------------------------------------------
    // Shared access and compare tasks
    // ------------------------------------------------------------------
    task automatic test_done;
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input string what, input logic [7:0] a,
        input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s %h expected %h seen %h", what, a, e, g);
        end
    endtask : chk

    task automatic acc(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q);
        bit ok;
        u_pcrb_host_model.xfer(w, a, d, q, ok);
        if (!ok)
        begin
            miscompares++;
            test_done();
        end
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk("register", a, {8'h00, e}, {8'h00, q});
    endtask : rd

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_defaults;
        for (int i = 0; i < 22; i++)
            rd(8'(i), i == 3 ? 8'h08 : 8'h00);
    endtask : t_defaults

    task automatic t_map;
        logic [7:0] m;
        for (int i = 0; i < 22; i++)
            wr(8'(i), 8'hFF);
        for (int i = 0; i < 22; i++)
        begin
            m = i == 3 ? 8'h7F : (i == 6 ? 8'h3F : 8'hFF);
            rd(8'(i), m);
        end
        wr(8'h16, 8'h00);
        wr(8'h1A, 8'h5A);
        rd(8'h16, 8'hA1);
        rd(8'h17, 8'hB2);
        rd(8'h18, 8'h10);
        rd(8'h19, 8'hD4);
        rd(8'h1A, 8'h00);
    endtask : t_map

    task automatic t_decode;
        logic [7:0] c[7] = '{8'h00, 8'h01, 8'h78, 8'h79, 8'hFA, 8'hFB, 8'hFF};
        logic [15:0] v[7] = '{16'h1388, 16'h1405, 16'h4E20, 16'h4F1A,
            16'hCD14, 16'hCF08, 16'hD6D8};
        wr(8'h08, 8'h00);
        for (int i = 0; i < 7; i++)
        begin
            wr(8'h07, c[i]);
            repeat (2) @(negedge clk);
            chk("target", c[i], v[i], target_tenth_mv);
        end
    endtask : t_decode

    task automatic t_droop;
        wr(8'h07, 8'h00);
        wr(8'h08, 8'h02);
        repeat (2) @(negedge clk);
        chk("droop", 8'h08, 16'h1368, target_tenth_mv);
        wr(8'h08, 8'h00);
    endtask : t_droop

    task automatic t_lock;
        logic [7:0] a[4] = '{8'h04, 8'h09, 8'h0A, 8'h14};
        @(posedge clk);
        output_on <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            wr(a[i], 8'h55);
            rd(a[i], 8'hFF);
        end
        wr(8'h05, 8'h55);
        rd(8'h05, 8'h55);
        @(posedge clk);
        output_on <= 1'b0;
        repeat (4) @(posedge clk);
        wr(8'h09, 8'h55);
        rd(8'h09, 8'h55);
    endtask : t_lock

    // A reset in mid-run stands for loss of input power.
    task automatic t_restore;
        @(posedge clk);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        t_defaults();
    endtask : t_restore

    // ------------------------------------------------------------------
    // Clock, reset and main sequence
    // ------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        miscompares = 0;
        tests_run = 0;
        reset = 1'b1;
        output_on = 1'b0;
        telemetry = '{flags: 8'hA1, voltage: 8'hB2, current: 8'h10,
            temperature: 8'hD4};
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        t_defaults();
        t_map();
        t_decode();
        t_droop();
        t_lock();
        t_restore();
        test_done();
    end
endmodule : tb_top

bind pcrb_register_bank pcrb_asserts u_pcrb_asserts (.clk(clk),
    .reset(reset), .req(req), .rsp(rsp), .output_on(output_on),
    .telemetry(telemetry), .config_out(config_out),
    .target_tenth_mv(target_tenth_mv));
